/* File: rtl/smoke_alarm_signal_sequencer.sv */
// Emitter, lamp, horn and interconnect sequencing of a smoke detector, all paced by one timebase.
`timescale 1ns/1ps
// Operation
// - The ir_emitter_drive output goes high for one pulse of the fast-phase width, nominally 105 us.
// - The ir_emitter_drive output is never high while the status lamp or either horn output is active.
// - Each emitter pulse sits near the end of its strobe window for smoke, chamber and button tests.
// - A rising edge on the interconnect input sets a flag that is sampled about every 672 ms (64 timebase periods) in standby.
// - Local smoke or button test makes the device source current on the interconnect line.
// - While the device sources the interconnect line, every input indication from it is ignored.
// - After power-on reset the interconnect line is disabled as both driver and input.
// - Local or remote smoke sounds a modulated tone on the horn pair for 24 of every 32 timebase periods.
// - Low supply or degraded chamber sounds only a short single chirp as the trouble indication.
// - The emitter period is 1024 timebase periods for smoke and chamber tests and 32 for button test.
// - A rising interconnect edge without local smoke starts the remote alarm within 800 ms.
// - The trouble chirp repeats every 4096 timebase periods and lasts one period.
// - Each active-low status lamp pulse lasts exactly one timebase period.
module smoke_alarm_signal_sequencer import smoke_seq_pkg::*; #(
   parameter int OSC_C = OSC_CYCLES,
   parameter int IR_C = IR_CYCLES,
   parameter int GUARD_C = IR_GUARD_CYCLES,
   parameter int TONE_C = TONE_HALF_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic localSmoke,
   input wire logic buttonTest,
   input wire logic lowSupply,
   input wire logic chamberFault,
   input wire logic ioIn,
   output logic ioOut,
   output logic ioOe,
   output logic irEmitterDrive,
   output logic strobeOut,
   output logic statusLampN,
   output logic lampOe,
   output logic hornA,
   output logic hornB,
   output logic remoteSmoke
);
   localparam int PW = $clog2(OSC_C);
   localparam logic [PW-1:0] IR_START = PW'(OSC_C - IR_C - GUARD_C);
   localparam logic [PW-1:0] IR_STOP = PW'(OSC_C - GUARD_C);
   localparam int TW = $clog2(TONE_C + 1);
   localparam logic [TW-1:0] TONE_LAST = TW'(TONE_C - 1);

   initial begin
      if (OSC_C <= IR_C + GUARD_C + 2 || IR_C < 1 || GUARD_C < 1 || TONE_C < 2) begin
         $error("smoke_alarm_signal_sequencer timing parameters inconsistent");
      end
   end

   logic tick;
   logic [PW-1:0] phase;
   logic [4:0] syncA_r;
   logic [4:0] syncB_r;
   logic smokeS, buttonS, lowS, chamberS, ioS;
   logic [CHAIN_W-1:0] chain_r;
   logic ioEnable_r;
   logic ioPrev_r;
   logic ioEdge_r;
   logic strobe_r;
   logic lampOn_r;
   logic chirp_r;
   logic alarmOn_r;
   logic tone_r;
   logic [TW-1:0] toneCnt_r;
   logic sampleNow;
   logic alarm;
   logic sounding;
   logic irNxt;

   osc_tick_gen #(.PERIOD(OSC_C)) u_tick (
      .mclk(mclk),
      .reset(reset),
      .tick(tick),
      .phase(phase)
   );

   // Two-stage synchronisers for all pin inputs.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         syncA_r <= 5'h00;
         syncB_r <= 5'h00;
      end else begin
         syncA_r <= {ioIn, chamberFault, lowSupply, buttonTest, localSmoke};
         syncB_r <= syncA_r;
      end
   end

   assign smokeS = syncB_r[0];
   assign buttonS = syncB_r[1];
   assign lowS = syncB_r[2];
   assign chamberS = syncB_r[3];
   assign ioS = syncB_r[4];
   assign alarm = smokeS | remoteSmoke;
   assign sounding = alarmOn_r | chirp_r;
   assign sampleNow = tick && (chain_r[5:0] == SAMPLE_SLOT) && !smokeS;

   // Single timebase chain advanced once per timebase period.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chain_r <= '0;
      end else if (tick) begin
         chain_r <= chain_r + 1'b1;
      end
   end

   // Interconnect stays dead until the first full timebase period after reset.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ioEnable_r <= 1'b0;
      end else if (tick) begin
         ioEnable_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ioOut <= 1'b0;
         ioOe <= 1'b0;
      end else begin
         ioOut <= ioEnable_r && (smokeS || buttonS);
         ioOe <= ioEnable_r && (smokeS || buttonS);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ioPrev_r <= 1'b0;
      end else begin
         ioPrev_r <= ioS;
      end
   end

   // Edge flag: a new edge wins over the sampling clear in the same cycle.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ioEdge_r <= 1'b0;
      end else if (!ioEnable_r || ioOe) begin
         ioEdge_r <= 1'b0;
      end else if (ioS && !ioPrev_r) begin
         ioEdge_r <= 1'b1;
      end else if (sampleNow) begin
         ioEdge_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         remoteSmoke <= 1'b0;
      end else if (!ioEnable_r || ioOe) begin
         remoteSmoke <= 1'b0;
      end else if (sampleNow) begin
         remoteSmoke <= ioEdge_r || (remoteSmoke && ioS);
      end
   end

   // Strobe window for smoke, chamber and button tests.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         strobe_r <= 1'b0;
      end else if (tick) begin
         strobe_r <= (chain_r[4:0] == STB_SLOT) && (buttonS || chain_r[9:5] == 5'h00);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         lampOn_r <= 1'b0;
      end else if (tick) begin
         if (smokeS || buttonS) begin
            lampOn_r <= (chain_r[5:0] == 6'h00);
         end else if (remoteSmoke) begin
            lampOn_r <= 1'b0;
         end else begin
            lampOn_r <= (chain_r == STANDBY_LAMP_SLOT);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chirp_r <= 1'b0;
      end else if (tick) begin
         chirp_r <= !alarm && ((lowS && chain_r == LOWSUP_CHIRP_SLOT) ||
                               (chamberS && chain_r == CHAMBER_CHIRP_SLOT));
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         alarmOn_r <= 1'b0;
      end else if (tick) begin
         alarmOn_r <= alarm && (chain_r[4:0] < HORN_ON_SLOTS);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         toneCnt_r <= '0;
         tone_r <= 1'b0;
      end else if (toneCnt_r == TONE_LAST) begin
         toneCnt_r <= '0;
         tone_r <= ~tone_r;
      end else begin
         toneCnt_r <= toneCnt_r + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hornA <= 1'b0;
         hornB <= 1'b0;
      end else begin
         hornA <= sounding && tone_r;
         hornB <= sounding && !tone_r;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         statusLampN <= 1'b1;
         lampOe <= 1'b0;
         strobeOut <= 1'b0;
      end else begin
         statusLampN <= !lampOn_r;
         lampOe <= lampOn_r;
         strobeOut <= strobe_r;
      end
   end

   // Emitter fires late in the strobe window and only when lamp and horn are idle.
   assign irNxt = strobe_r && (phase >= IR_START) && (phase < IR_STOP) && !lampOn_r && !sounding;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irEmitterDrive <= 1'b0;
      end else begin
         irEmitterDrive <= irNxt;
      end
   end

   logic [31:0] irLen_r;
   logic [31:0] lampLen_r;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irLen_r <= '0;
         lampLen_r <= '0;
      end else begin
         irLen_r <= irEmitterDrive ? irLen_r + 1 : 32'h00000000;
         lampLen_r <= !statusLampN ? lampLen_r + 1 : 32'h00000000;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_ir_no_lamp: assert property (irEmitterDrive |-> statusLampN && !lampOe) else $error("emitter overlaps lamp");
   a_ir_no_horn: assert property (irEmitterDrive |-> !hornA && !hornB) else $error("emitter overlaps horn");
   a_ir_in_strobe: assert property (irEmitterDrive |-> strobeOut && strobe_r) else $error("emitter outside strobe");
   a_ir_pulse_width: assert property ($fell(irEmitterDrive) |-> $past(irLen_r) == 32'(IR_C - 1))
      else $error("emitter width wrong");
   a_lamp_width_one: assert property ($rose(statusLampN) |-> $past(lampLen_r) == 32'(OSC_C - 1))
      else $error("lamp width wrong");
   a_strobe_slot_pos: assert property ($rose(strobe_r) |-> $past(chain_r[4:0]) == STB_SLOT &&
      ($past(buttonS) || $past(chain_r[9:5]) == 5'h00)) else $error("strobe off schedule");
   a_horn_push_pull: assert property (hornA |-> !hornB) else $error("horn outputs not complementary");
   a_alarm_sounds: assert property ($rose(alarmOn_r) |=> hornA || hornB) else $error("alarm silent");
   a_chirp_not_alarm: assert property (chirp_r |-> !alarmOn_r) else $error("chirp during alarm");
   a_edge_sets_flag: assert property (ioS && !ioPrev_r && ioEnable_r && !ioOe |=> ioEdge_r)
      else $error("edge not captured");
   a_drive_ignores_in: assert property (ioOe |=> !ioEdge_r && !remoteSmoke) else $error("input seen while driving");
   a_por_io_off: assert property (!ioEnable_r |-> !ioOe && !ioEdge_r && !remoteSmoke)
      else $error("interconnect active after reset");
   a_remote_follows: assert property (sampleNow && ioEdge_r && ioEnable_r && !ioOe |=> remoteSmoke)
      else $error("remote alarm not started");
   a_chain_step_one: assert property (tick |=> chain_r == $past(chain_r) + 1'b1) else $error("chain did not advance");

   c_ir_fires: cover property ($rose(irEmitterDrive));
   c_local_alarm: cover property (smokeS && hornA);
   c_remote_alarm: cover property ($rose(remoteSmoke));
   c_trouble_chirp: cover property ($rose(chirp_r));
endmodule

/* File: inc/smoke_seq_pkg.sv */
// Shared timing constants and schedule slots for the smoke alarm signal sequencer.
package smoke_seq_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OSC_PERIOD_NS = 10_500_000;
   localparam int IR_WIDTH_NS = 105_000;
   localparam int IR_GUARD_NS = 10_000;
   localparam int TONE_HALF_NS = 156_000;
   localparam int OSC_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int IR_CYCLES = (IR_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IR_GUARD_CYCLES = (IR_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TONE_HALF_CYCLES = TONE_HALF_NS / CLK_PERIOD_NS;
   localparam int CHAIN_W = 12;
   localparam logic [4:0] STB_SLOT = 5'h1c;
   localparam logic [4:0] HORN_ON_SLOTS = 5'h18;
   localparam logic [5:0] SAMPLE_SLOT = 6'h20;
   localparam logic [11:0] LOWSUP_CHIRP_SLOT = 12'h000;
   localparam logic [11:0] CHAMBER_CHIRP_SLOT = 12'h800;
   localparam logic [11:0] STANDBY_LAMP_SLOT = 12'h000;
endpackage

/* File: rtl/osc_tick_gen.sv */
// Divides mclk into the timebase_oscillator period with a phase count and an end-of-period tick.
`timescale 1ns/1ps
module osc_tick_gen #(
   parameter int PERIOD = 1050000
) (
   input wire logic mclk,
   input wire logic reset,
   output logic tick,
   output logic [$clog2(PERIOD)-1:0] phase
);
   localparam int PW = $clog2(PERIOD);
   localparam logic [PW-1:0] LAST = PW'(PERIOD - 1);

   initial begin
      if (PERIOD < 4) begin
         $error("osc_tick_gen PERIOD too small");
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phase <= '0;
      end else if (phase == LAST) begin
         phase <= '0;
      end else begin
         phase <= phase + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tick <= 1'b0;
      end else begin
         tick <= (phase == LAST - 1'b1);
      end
   end
endmodule

/* File: tb/remote_unit_model.sv */
// Model of the other units that share the interconnect line.
`timescale 1ns/1ps
module remote_unit_model (
   input wire logic ioOut,
   input wire logic ioOe,
   input wire logic srcEn,
   output logic lineLvl
);
   // The line is wired-OR and the on-chip sink pulls it low when no unit sources.
   assign lineLvl = (ioOe & ioOut) | srcEn;
endmodule

/* File: tb/smoke_alarm_signal_sequencer_tb_top.sv */
// Self-checking bench for the smoke alarm signal sequencer.
`timescale 1ns/1ps
module smoke_alarm_signal_sequencer_tb_top;
   import smoke_seq_pkg::*;
   localparam int OC = 8;
   logic mclk, reset, localSmoke, buttonTest, lowSupply, chamberFault, srcEn, ioIn;
   logic ioOut, ioOe, irEmitterDrive, strobeOut, statusLampN, lampOe, hornA, hornB, remoteSmoke;
   logic pIr = 0, pLamp = 0, pHorn = 0, pStb = 0;
   logic [31:0] lfsr = 32'h74d212f8;
   int fail_count = 0, tests_run = 0, cyc = 0;
   int wIr = 0, wLamp = 0, wHorn = 0, tStb = 0, tHorn = 0;
   int irQ[$], lampQ[$], hornQ[$], stbPerQ[$], hornPerQ[$];

   smoke_alarm_signal_sequencer #(.OSC_C(OC), .IR_C(4), .GUARD_C(1), .TONE_C(2))
      smoke_alarm_signal_sequencer_inst (.mclk(mclk), .reset(reset), .localSmoke(localSmoke),
      .buttonTest(buttonTest), .lowSupply(lowSupply), .chamberFault(chamberFault), .ioIn(ioIn),
      .ioOut(ioOut), .ioOe(ioOe), .irEmitterDrive(irEmitterDrive), .strobeOut(strobeOut),
      .statusLampN(statusLampN), .lampOe(lampOe), .hornA(hornA), .hornB(hornB), .remoteSmoke(remoteSmoke));

   remote_unit_model remote_unit_model_inst (.ioOut(ioOut), .ioOe(ioOe), .srcEn(srcEn), .lineLvl(ioIn));

   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task check_width(input int expv, input int got);
      tests_run++;
      if (got != expv) begin
         fail_count++;
         $display("[FAIL] %0t exp %h got %h", $time, expv, got);
      end
   endtask

   task check_bit(input logic expv, input logic got);
      tests_run++;
      if (got !== expv) begin
         fail_count++;
         $display("[FAIL] %0t exp %h got %h", $time, expv, got);
      end
   endtask

   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Waits for the horn pair or the strobe to reach a level, bounded.
   task automatic wait_lvl(input bit hornSel, input logic v, input int lim);
      int n;
      n = 0;
      while ((hornSel ? hornA ^ hornB : strobeOut) !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
      check_bit(v, hornSel ? hornA ^ hornB : strobeOut);
   endtask

   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end

   // Measures pulse widths and periods and compares them with the oldest notes.
   always @(posedge mclk) begin
      cyc++;
      if (irEmitterDrive === 1'b1) begin
         wIr++;
         check_bit(1'b1, strobeOut & statusLampN & ~hornA & ~hornB);
      end else if (pIr) begin
         if (irQ.size() > 0) check_width(irQ.pop_front(), wIr);
         wIr = 0;
      end
      if (statusLampN === 1'b0) begin
         wLamp++;
      end else if (pLamp) begin
         if (lampQ.size() > 0) check_width(lampQ.pop_front(), wLamp);
         wLamp = 0;
      end
      if ((hornA ^ hornB) === 1'b1) begin
         if (!pHorn && hornPerQ.size() > 0) check_width(hornPerQ.pop_front(), cyc - tHorn);
         if (!pHorn) tHorn = cyc;
         wHorn++;
      end else if (pHorn) begin
         if (hornQ.size() > 0) check_width(hornQ.pop_front(), wHorn);
         wHorn = 0;
      end
      if (strobeOut === 1'b1 && !pStb) begin
         if (stbPerQ.size() > 0) check_width(stbPerQ.pop_front(), cyc - tStb);
         tStb = cyc;
      end
      if ((hornA | hornB) === 1'b1) check_bit(1'b0, hornA & hornB);
      pIr = irEmitterDrive;
      pLamp = !statusLampN;
      pHorn = hornA ^ hornB;
      pStb = strobeOut;
   end

   initial begin
      reset = 1;
      localSmoke = 0;
      buttonTest = 1;
      lowSupply = 0;
      chamberFault = 0;
      srcEn = 0;
      repeat (8) @(negedge mclk);
      check_bit(1'b1, statusLampN);
      reset = 0;
      srcEn = 0;
      repeat (4) @(negedge mclk);
      check_bit(1'b0, ioOe);
      repeat (2 * OC) @(negedge mclk);
      check_bit(1'b1, ioOe);
      wait_lvl(0, 1'b1, 40 * OC);
      irQ.push_back(4);
      lampQ.push_back(OC);
      wait_lvl(0, 1'b0, 2 * OC);
      stbPerQ.push_back(32 * OC);
      wait_lvl(0, 1'b1, 40 * OC);
      srcEn = 0;
      @(negedge mclk);
      srcEn = 1;
      repeat (140 * OC) @(negedge mclk);
      check_bit(1'b0, remoteSmoke);
      buttonTest = 0;
      srcEn = 0;
      lfsr = next_rnd(lfsr);
      repeat (lfsr[5:0] + 4) @(negedge mclk);
      srcEn = 1;
      wait_lvl(1, 1'b1, 76 * OC);
      check_bit(1'b0, ioOe);
      wait_lvl(1, 1'b0, 32 * OC);
      wait_lvl(1, 1'b1, 32 * OC);
      hornQ.push_back(24 * OC);
      wait_lvl(1, 1'b0, 32 * OC);
      hornPerQ.push_back(32 * OC);
      wait_lvl(1, 1'b1, 32 * OC);
      srcEn = 0;
      repeat (140 * OC) @(negedge mclk);
      check_bit(1'b0, hornA | hornB);
      localSmoke = 1;
      wait_lvl(1, 1'b1, 34 * OC);
      check_bit(1'b1, ioOe);
      check_bit(1'b0, remoteSmoke);
      localSmoke = 0;
      wait_lvl(1, 1'b0, 3 * OC);
      lowSupply = 1;
      wait_lvl(1, 1'b1, 4200 * OC);
      hornQ.push_back(OC);
      wait_lvl(1, 1'b0, 2 * OC);
      hornPerQ.push_back(4096 * OC);
      wait_lvl(1, 1'b1, 4200 * OC);
      hornQ.push_back(OC);
      lowSupply = 0;
      chamberFault = 1;
      wait_lvl(1, 1'b0, 2 * OC);
      hornPerQ.push_back(2048 * OC);
      wait_lvl(1, 1'b1, 2100 * OC);
      hornQ.push_back(OC);
      repeat (2 * OC) @(negedge mclk);
      complete_run();
   end

   initial begin
      repeat (95000) @(posedge mclk);
      fail_count++;
      complete_run();
   end
endmodule
